// [call_clear_pkg.sv]
// constants and types shared by the call and clear instruction executor
package call_clear_pkg;

  // width of one data memory word
  localparam int DATA_WIDTH = 8;
  // width of a bit position within one data memory word
  localparam int BIT_SEL_WIDTH = 3;
  // default widths of the program counter and stack words (12) and of the data memory address (8)
  localparam int PC_WIDTH_DEFAULT = 12;
  localparam int MEM_ADDR_WIDTH_DEFAULT = 8;

  // instruction kinds handed over by the instruction decoder
  localparam int OP_WIDTH = 3;
  localparam logic [OP_WIDTH-1:0] OP_CALL = 3'h0;
  localparam logic [OP_WIDTH-1:0] OP_CLEAR_MEMORY_BYTE = 3'h1;
  localparam logic [OP_WIDTH-1:0] OP_CLEAR_MEMORY_BIT = 3'h2;
  localparam logic [OP_WIDTH-1:0] OP_WATCHDOG_CLEAR_SINGLE = 3'h3;
  localparam logic [OP_WIDTH-1:0] OP_WATCHDOG_PRECLEAR_FIRST = 3'h4;
  localparam logic [OP_WIDTH-1:0] OP_WATCHDOG_PRECLEAR_SECOND = 3'h5;

  // value written by a whole byte clear
  localparam logic [DATA_WIDTH-1:0] CLEARED_BYTE = 8'h00;
  // step from the call instruction to the return address
  localparam int RETURN_STEP = 1;
  // machine cycles spent on one subroutine call
  localparam int CALL_CYCLES = 2;

  // execution sequence
  typedef enum logic [0:0] {
    st_idle,
    st_call_load
  } exec_state_e;

  // history of the paired pre-clear instructions
  typedef enum logic [1:0] {
    pre_none,
    pre_first_seen,
    pre_second_seen
  } preclear_state_e;

  // preclear history code for the status output
  localparam logic [1:0] PRE_CODE_NONE = 2'h0;
  localparam logic [1:0] PRE_CODE_FIRST = 2'h1;
  localparam logic [1:0] PRE_CODE_SECOND = 2'h2;

endpackage

// [call_and_clear_instr_exec.sv]
// execution of the call, memory clear and watchdog clear instructions
// Notes on behaviour
// - call pushes program counter plus one
// - call then loads target into program counter
// - call takes two machine cycles
// - byte clear writes zero to addressed location
// - bit clear zeroes only the selected bit
// - single watchdog clear resets counter and flags
// - first pre-clear acts only after second
// - repeated first pre-clear alone does nothing
// - second pre-clear acts only after first
// - pre-clear pair clears flags only after both consecutively executed
module call_and_clear_instr_exec
  import call_clear_pkg::*;
#(
  parameter int PC_WIDTH = call_clear_pkg::PC_WIDTH_DEFAULT,
  parameter int MEM_ADDR_WIDTH = call_clear_pkg::MEM_ADDR_WIDTH_DEFAULT
) (
  input wire logic clock, // instruction clock
  input wire logic sys_rst, // asynchronous reset, active high
  input wire logic instr_valid, // decoder offers an instruction
  input wire logic [call_clear_pkg::OP_WIDTH-1:0] instr_op, // instruction kind
  input wire logic [PC_WIDTH-1:0] instr_pc, // address of the offered instruction
  input wire logic [PC_WIDTH-1:0] instr_target, // call target address
  input wire logic [MEM_ADDR_WIDTH-1:0] instr_mem_addr, // addressed data memory location
  input wire logic [call_clear_pkg::BIT_SEL_WIDTH-1:0] instr_bit_sel, // bit position
  input wire logic [call_clear_pkg::DATA_WIDTH-1:0] mem_rdata, // current word at instr_mem_addr
  output logic instr_ready, // executor can take an instruction this cycle
  output logic stack_push, // push one return address
  output logic [PC_WIDTH-1:0] stack_data, // return address to push
  output logic pc_load, // load the program counter
  output logic [PC_WIDTH-1:0] pc_target, // new program counter value
  output logic mem_we, // write one data memory word
  output logic [MEM_ADDR_WIDTH-1:0] mem_waddr, // data memory write address
  output logic [call_clear_pkg::DATA_WIDTH-1:0] mem_wdata, // data memory write data
  output logic watchdog_counter_clear, // reset the watchdog counter
  output logic timeout_flag_clear, // clear the timeout flag
  output logic powerdown_flag_clear, // clear the power-down flag
  output logic [1:0] preclear_history, // which pre-clear still waits for its partner
  output logic instr_unknown // offered kind is not handled here
);
  import call_clear_pkg::*;

  // mask with a single zero at the chosen bit position
  function automatic logic [DATA_WIDTH-1:0] keep_mask(input logic [BIT_SEL_WIDTH-1:0] sel);
    logic [DATA_WIDTH-1:0] m;
    m = {DATA_WIDTH{1'b1}};
    m[sel] = 1'b0;
    return m;
  endfunction

  exec_state_e state;
  exec_state_e next_state;
  preclear_state_e preclear;
  preclear_state_e next_preclear;
  logic [PC_WIDTH-1:0] call_target;

  // accept decode
  wire logic take;
  wire logic is_call;
  wire logic is_byte;
  wire logic is_bit;
  wire logic is_single;
  wire logic is_first;
  wire logic is_second;
  wire logic is_known;

  assign take = instr_valid && instr_ready;
  assign is_call = take && (instr_op == OP_CALL);
  assign is_byte = take && (instr_op == OP_CLEAR_MEMORY_BYTE);
  assign is_bit = take && (instr_op == OP_CLEAR_MEMORY_BIT);
  assign is_single = take && (instr_op == OP_WATCHDOG_CLEAR_SINGLE);
  assign is_first = take && (instr_op == OP_WATCHDOG_PRECLEAR_FIRST);
  assign is_second = take && (instr_op == OP_WATCHDOG_PRECLEAR_SECOND);
  assign is_known = is_call || is_byte || is_bit || is_single || is_first || is_second;

  // return address is the word after the call
  wire logic [PC_WIDTH-1:0] return_addr;
  assign return_addr = PC_WIDTH'(instr_pc + PC_WIDTH'(RETURN_STEP));

  // memory write data: whole byte zero or read-modify-write of one bit
  wire logic [DATA_WIDTH-1:0] bit_cleared;
  wire logic [DATA_WIDTH-1:0] next_wdata;
  wire logic next_we;
  assign bit_cleared = mem_rdata & keep_mask(instr_bit_sel);
  assign next_wdata = is_bit ? bit_cleared : CLEARED_BYTE;
  assign next_we = is_byte || is_bit;

  // pre-clear pairing: one of each kind in turn makes a clear.
  // other instructions except the single clear, which ends it, do not break the pairing; a repeat of the same kind
  // restarts it, so a pair split by ordinary code still counts as consecutive.
  wire logic pair_done;
  assign pair_done = (is_first && (preclear == pre_second_seen))
                  || (is_second && (preclear == pre_first_seen));

  always_comb begin
    next_preclear = preclear;
    if (pair_done) begin
      next_preclear = pre_none;
    end else if (is_first) begin
      next_preclear = pre_first_seen;
    end else if (is_second) begin
      next_preclear = pre_second_seen;
    end else if (is_single) begin
      next_preclear = pre_none;
    end
  end

  // watchdog and flag clears come only from the single clear or a finished pair,
  // so call and memory clears never touch the flags
  wire logic next_wd_clear;
  assign next_wd_clear = is_single || pair_done;

  // sequence: a call holds the executor for a second cycle
  always_comb begin
    next_state = state;
    unique case (state)
      st_idle: begin
        if (is_call) begin
          next_state = st_call_load;
        end
      end
      st_call_load: begin
        next_state = st_idle;
      end
    endcase
  end

  // the preclear history as a plain code for observers
  wire logic [1:0] next_history;
  assign next_history = (next_preclear == pre_first_seen) ? PRE_CODE_FIRST :
                        (next_preclear == pre_second_seen) ? PRE_CODE_SECOND :
                        PRE_CODE_NONE;

  // state registers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= st_idle;
      preclear <= pre_none;
    end else begin
      state <= next_state;
      preclear <= next_preclear;
    end
  end

  // held call target between the push and the load
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      call_target <= '0;
    end else if (is_call) begin
      call_target <= instr_target;
    end
  end

  // ready drops during the first call cycle, with the push; the core must hold off fetch
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      instr_ready <= 1'b1;
    end else begin
      instr_ready <= (next_state == st_idle);
    end
  end

  // first call cycle: push the return address
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stack_push <= 1'b0;
      stack_data <= '0;
    end else begin
      stack_push <= is_call;
      if (is_call) begin
        stack_data <= return_addr;
      end
    end
  end

  // second call cycle: load the target, fetch resumes from it unconditionally
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pc_load <= 1'b0;
      pc_target <= '0;
    end else begin
      pc_load <= (state == st_call_load);
      if (state == st_call_load) begin
        pc_target <= call_target;
      end
    end
  end

  // data memory write port
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mem_we <= 1'b0;
      mem_waddr <= '0;
      mem_wdata <= '0;
    end else begin
      mem_we <= next_we;
      if (next_we) begin
        mem_waddr <= instr_mem_addr;
        mem_wdata <= next_wdata;
      end
    end
  end

  // watchdog counter and flag clear strobes, all three together
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      watchdog_counter_clear <= 1'b0;
      timeout_flag_clear <= 1'b0;
      powerdown_flag_clear <= 1'b0;
    end else begin
      watchdog_counter_clear <= next_wd_clear;
      timeout_flag_clear <= next_wd_clear;
      powerdown_flag_clear <= next_wd_clear;
    end
  end

  // observation outputs
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      preclear_history <= PRE_CODE_NONE;
      instr_unknown <= 1'b0;
    end else begin
      preclear_history <= next_history;
      instr_unknown <= take && !is_known;
    end
  end

endmodule

// [call_clear_assertions.sv]
// port level assertions for the call and clear instruction executor
module call_clear_assertions
  import call_clear_pkg::*;
#(parameter int PC_WIDTH = 12, parameter int MEM_ADDR_WIDTH = 8) (
  input wire logic clock, // clock
  input wire logic sys_rst, // reset
  input wire logic instr_valid, // offer
  input wire logic [call_clear_pkg::OP_WIDTH-1:0] instr_op, // kind
  input wire logic [PC_WIDTH-1:0] instr_pc, // address
  input wire logic [PC_WIDTH-1:0] instr_target, // target
  input wire logic [call_clear_pkg::BIT_SEL_WIDTH-1:0] instr_bit_sel, // bit
  input wire logic [call_clear_pkg::DATA_WIDTH-1:0] mem_rdata, // word read
  input wire logic instr_ready, // ready
  input wire logic stack_push, // push
  input wire logic [PC_WIDTH-1:0] stack_data, // return address
  input wire logic pc_load, // load
  input wire logic [PC_WIDTH-1:0] pc_target, // new pc
  input wire logic mem_we, // write
  input wire logic [call_clear_pkg::DATA_WIDTH-1:0] mem_wdata, // write data
  input wire logic watchdog_counter_clear, // counter clear
  input wire logic timeout_flag_clear, // flag clear
  input wire logic [1:0] preclear_history // history
);
  // a take is an offer accepted at this edge
  wire take = instr_valid && instr_ready;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_call; take && instr_op == OP_CALL; endsequence
  sequence s_call_steps; stack_push && !instr_ready ##1 pc_load && instr_ready; endsequence
  property p_call_push; s_call |=> stack_data == PC_WIDTH'($past(instr_pc) + 1); endproperty
  a_call_push: assert property (p_call_push) else $error("return address wrong");
  property p_call_target; s_call |-> ##2 pc_target == $past(instr_target, 2); endproperty
  a_call_target: assert property (p_call_target) else $error("call target wrong");
  property p_call_steps; s_call |=> s_call_steps; endproperty
  a_call_steps: assert property (p_call_steps) else $error("call cycles wrong");
  property p_byte; take && instr_op == OP_CLEAR_MEMORY_BYTE |=> mem_we && mem_wdata == 8'h00; endproperty
  a_byte: assert property (p_byte) else $error("byte clear wrong");
  property p_bit; take && instr_op == OP_CLEAR_MEMORY_BIT |=> mem_we
    && mem_wdata == ($past(mem_rdata) & ~(8'h01 << $past(instr_bit_sel))); endproperty
  a_bit: assert property (p_bit) else $error("bit clear wrong");
  property p_single; take && instr_op == OP_WATCHDOG_CLEAR_SINGLE |=> watchdog_counter_clear
    && timeout_flag_clear; endproperty
  a_single: assert property (p_single) else $error("single clear missing");
  property p_pair; take && (instr_op == OP_WATCHDOG_PRECLEAR_SECOND ? preclear_history == PRE_CODE_FIRST
    : instr_op == OP_WATCHDOG_PRECLEAR_FIRST && preclear_history == PRE_CODE_SECOND)
    |=> timeout_flag_clear && preclear_history == PRE_CODE_NONE; endproperty
  a_pair: assert property (p_pair) else $error("pair clear missing");
  property p_rep_first; take && instr_op == OP_WATCHDOG_PRECLEAR_FIRST
    && preclear_history == PRE_CODE_FIRST |=> !watchdog_counter_clear; endproperty
  a_rep_first: assert property (p_rep_first) else $error("repeat first cleared");
  property p_rep_second; take && instr_op == OP_WATCHDOG_PRECLEAR_SECOND
    && preclear_history == PRE_CODE_SECOND |=> !timeout_flag_clear; endproperty
  a_rep_second: assert property (p_rep_second) else $error("repeat second cleared");
  property p_keep; take && instr_op <= OP_CLEAR_MEMORY_BIT |=> !timeout_flag_clear; endproperty
  a_keep: assert property (p_keep) else $error("flags touched");
endmodule
bind call_and_clear_instr_exec call_clear_assertions #(.PC_WIDTH(PC_WIDTH),
  .MEM_ADDR_WIDTH(MEM_ADDR_WIDTH)) u_call_clear_assertions (.clock, .sys_rst, .instr_valid,
  .instr_op, .instr_pc, .instr_target, .instr_bit_sel, .mem_rdata, .instr_ready, .stack_push,
  .stack_data, .pc_load, .pc_target, .mem_we, .mem_wdata, .watchdog_counter_clear,
  .timeout_flag_clear, .preclear_history);

// [tb.sv]
// self-checking bench for the call and clear instruction executor
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import call_clear_pkg::*;
  logic clock = 1'h0, sys_rst = 1'h1, instr_valid = 1'h0;
  logic [2:0] instr_op = 3'h0, instr_bit_sel = 3'h0;
  logic [11:0] instr_pc = 12'h000, instr_target = 12'h000, stack_data, pc_target;
  logic [7:0] instr_mem_addr = 8'h00, mem_rdata = 8'h00, mem_waddr, mem_wdata;
  logic instr_ready, stack_push, pc_load, mem_we, watchdog_counter_clear;
  logic timeout_flag_clear, powerdown_flag_clear, instr_unknown;
  logic [1:0] preclear_history;
  int err_count = 0, samples_checked = 0;
  call_and_clear_instr_exec u_call_and_clear_instr_exec (.clock, .sys_rst, .instr_valid,
    .instr_op, .instr_pc, .instr_target, .instr_mem_addr, .instr_bit_sel, .mem_rdata,
    .instr_ready, .stack_push, .stack_data, .pc_load, .pc_target, .mem_we, .mem_waddr,
    .mem_wdata, .watchdog_counter_clear, .timeout_flag_clear, .powerdown_flag_clear,
    .preclear_history, .instr_unknown);
  // free running clock
  initial forever #4 clock = ~clock;
  // wide enough for the longest packed group compared below, so no field is cut off
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // offer one instruction and hold it until taken; returns in the first answer cycle
  task automatic issue(input logic [2:0] op);
    int n;
    n = 0;
    @(posedge clock);
    #1;
    instr_op = op;
    instr_valid = 1'h1;
    while (instr_ready !== 1'h1) begin
      n++;
      if (n > 4) begin
        err_count++;
        report_and_stop();
      end
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    #1;
    instr_valid = 1'h0;
  endtask
  // the return address wraps at the top of the program space
  task automatic t_call();
    instr_pc = 12'hFFF;
    instr_target = 12'h234;
    issue(OP_CALL);
    chk("stack_push", stack_push, 1'h1);
    chk("stack_data", stack_data, 12'h000);
    chk("ready_c1", {instr_ready, pc_load}, 2'h0);
    @(posedge clock);
    #1;
    chk("pc_load", {pc_load, instr_ready}, 2'h3);
    chk("pc_target", pc_target, 12'h234);
    chk("call_flags", {timeout_flag_clear, powerdown_flag_clear}, 2'h0);
    $display("t_call done");
  endtask
  task automatic t_mem();
    instr_mem_addr = 8'hA5;
    mem_rdata = 8'hFF;
    issue(OP_CLEAR_MEMORY_BYTE);
    chk("byte_write", {mem_we, mem_waddr, mem_wdata}, {1'h1, 8'hA5, 8'h00});
    for (int i = 0; i < 8; i++) begin
      instr_bit_sel = i[2:0];
      issue(OP_CLEAR_MEMORY_BIT);
      chk("bit_write", {mem_we, mem_waddr, mem_wdata}, {1'h1, 8'hA5, 8'hFF & ~(8'h01 << i)});
      chk("bit_flags", {watchdog_counter_clear, timeout_flag_clear, powerdown_flag_clear}, 3'h0);
    end
    $display("t_mem done");
  endtask
  // single, repeats, a pair, a pair across another instruction, then an unknown kind
  task automatic t_watchdog();
    logic [2:0] ops [9] = '{3'h3, 3'h4, 3'h4, 3'h5, 3'h5, 3'h5, 3'h1, 3'h4, 3'h6};
    logic st [9] = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0};
    logic [1:0] hist [9] = '{2'h0, 2'h1, 2'h1, 2'h0, 2'h2, 2'h2, 2'h2, 2'h0, 2'h0};
    for (int i = 0; i < 9; i++) begin
      issue(ops[i]);
      chk("strobes", {watchdog_counter_clear, timeout_flag_clear, powerdown_flag_clear}, {3{st[i]}});
      chk("history", preclear_history, hist[i]);
      chk("unknown", instr_unknown, ops[i] == 3'h6);
    end
    $display("t_watchdog done");
  endtask
  initial begin
    repeat (3) @(posedge clock);
    #1;
    sys_rst = 1'h0;
    t_call();
    t_mem();
    t_watchdog();
    report_and_stop();
  end
endmodule
